// File: rtl/xl_addr_dec.sv
// Module: address decoder of the register bank
`timescale 1ns/1ps
`default_nettype none

module xl_addr_dec (
  input  wire logic [5:0] bus_addr,
  input  wire logic       bus_rd_en,
  input  wire logic       bus_wr_en,
  xl_sel_if.dec           sel
);

  always_comb begin
    sel.sel_rx_xbit = (bus_addr == xl_pkg::RX_DS2_XBIT_STATUS_OFS);
    sel.sel_tx_xbit = (bus_addr == xl_pkg::TX_DS2_XBIT_CONTROL_OFS);
    sel.sel_alarm   = (bus_addr == xl_pkg::LATCHED_DS3_RX_ALARMS_OFS);
    sel.sel_cbit    = (bus_addr == xl_pkg::LATCHED_CBIT_DS2_FRAME_STATUS_OFS);
    sel.sel_test    = (bus_addr == xl_pkg::FACTORY_TEST_OFS);
    // Write wins nothing: a cycle with both strobes is treated as a read
    sel.rd          = bus_rd_en;
    sel.wr          = bus_wr_en & ~bus_rd_en;
  end

endmodule

`default_nettype wire

// File: rtl/xl_pkg.sv
// Package: register map, field positions and reset values of the X-bit/alarm bank
package xl_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TRIB_N = 7;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] RX_DS2_XBIT_STATUS_OFS            = 6'h14;
  localparam logic [5:0] TX_DS2_XBIT_CONTROL_OFS           = 6'h15;
  localparam logic [5:0] LATCHED_DS3_RX_ALARMS_OFS         = 6'h16;
  localparam logic [5:0] LATCHED_CBIT_DS2_FRAME_STATUS_OFS = 6'h17;
  localparam logic [5:0] FACTORY_TEST_OFS                  = 6'h18;

  // ----------------------------------------------------------------------
  // Field positions, latched receive alarm register
  // ----------------------------------------------------------------------
  localparam int unsigned LINE_LOS_BIT    = 7;
  localparam int unsigned LINE_OOF_BIT    = 6;
  localparam int unsigned LINE_AIS_BIT    = 5;
  localparam int unsigned LINE_IDLE_BIT   = 4;
  localparam int unsigned RX_CKF_BIT      = 3;
  localparam int unsigned TX_CKF_BIT      = 2;
  localparam int unsigned XBIT_TWO_BIT    = 1;
  localparam int unsigned XBIT_ONE_BIT    = 0;

  // Latched C-bit / DS2 frame status register
  localparam int unsigned CBIT_ERROR_BIT  = 7;

  // ----------------------------------------------------------------------
  // Reset values, unmapped read data and X-bit read mask
  // ----------------------------------------------------------------------
  localparam logic [6:0] TX_XBIT_RESET    = 7'h7F;
  localparam logic [7:0] STICKY_RESET     = 8'h00;
  localparam logic [7:0] RD_DATA_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;
  localparam logic [7:0] XBIT_POS_MASK    = 8'h03;

endpackage

// File: rtl/xl_sel_if.sv
// Interface: decoded register selects and strobes from decoder to the bank
`timescale 1ns/1ps
`default_nettype none

interface xl_sel_if;
  logic sel_rx_xbit;
  logic sel_tx_xbit;
  logic sel_alarm;
  logic sel_cbit;
  logic sel_test;
  logic rd;
  logic wr;

  modport dec (
    output sel_rx_xbit,
    output sel_tx_xbit,
    output sel_alarm,
    output sel_cbit,
    output sel_test,
    output rd,
    output wr
  );

  modport bank (
    input  sel_rx_xbit,
    input  sel_tx_xbit,
    input  sel_alarm,
    input  sel_cbit,
    input  sel_test,
    input  rd,
    input  wr
  );
endinterface

`default_nettype wire

// File: rtl/xl_sticky.sv
// Module: eight sticky event bits, set by hardware, cleared by a read
`timescale 1ns/1ps
`default_nettype none

module xl_sticky (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] set_vec,
  input  wire logic       clr,
  output logic      [7:0] q
);

  logic [7:0] q_reg;
  logic [7:0] q_next;

  // Set beats clear so an event in the clearing cycle stays latched
  always_comb begin
    q_next = set_vec | (q_reg & ~{8{clr}});
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= xl_pkg::STICKY_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

`default_nettype wire

// File: rtl/xl_xbit_alarm_regs.sv
// Module: DS2 X-bit control/status and latched alarm register bank (top)
`timescale 1ns/1ps
`default_nettype none

module xl_xbit_alarm_regs (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [5:0] bus_addr,
  input  wire logic [7:0] bus_wr_data,
  input  wire logic       bus_rd_en,
  input  wire logic       bus_wr_en,
  output logic      [7:0] bus_rd_data,
  input  wire logic [6:0] rx_tributary_xbit,
  output logic      [6:0] tx_tributary_xbit,
  input  wire logic       line_los,
  input  wire logic       line_oof,
  input  wire logic       line_ais,
  input  wire logic       line_idle,
  input  wire logic       rx_clock_fail,
  input  wire logic       tx_clock_fail,
  input  wire logic [1:0] line_xbit,
  input  wire logic       c1_valid,
  input  wire logic       c1_bit,
  input  wire logic [6:0] tributary_oof
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  xl_sel_if sel ();

  xl_addr_dec u_dec (
    .bus_addr  (bus_addr),
    .bus_rd_en (bus_rd_en),
    .bus_wr_en (bus_wr_en),
    .sel       (sel)
  );

  // ----------------------------------------------------------------------
  // Transmit X-bit control
  // ----------------------------------------------------------------------
  logic [6:0] tx_xbit_reg;

  // Bit 7 is not stored, so a stray 1 from software cannot matter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_xbit_reg <= xl_pkg::TX_XBIT_RESET;
    end else if (sel.wr && sel.sel_tx_xbit) begin
      tx_xbit_reg <= bus_wr_data[6:0];
    end
  end

  assign tx_tributary_xbit = tx_xbit_reg;

  // ----------------------------------------------------------------------
  // Latched receive alarms
  // ----------------------------------------------------------------------
  logic [7:0] alarm_set;
  logic [7:0] alarm_q;

  always_comb begin
    alarm_set                          = 8'h00;
    alarm_set[xl_pkg::LINE_LOS_BIT]    = line_los;
    alarm_set[xl_pkg::LINE_OOF_BIT]    = line_oof;
    alarm_set[xl_pkg::LINE_AIS_BIT]    = line_ais;
    alarm_set[xl_pkg::LINE_IDLE_BIT]   = line_idle;
    alarm_set[xl_pkg::RX_CKF_BIT]      = rx_clock_fail;
    alarm_set[xl_pkg::TX_CKF_BIT]      = tx_clock_fail;
    // A received X-bit of 0 is the event; stored positive, read inverted
    alarm_set[xl_pkg::XBIT_TWO_BIT]    = ~line_xbit[1];
    alarm_set[xl_pkg::XBIT_ONE_BIT]    = ~line_xbit[0];
  end

  xl_sticky u_alarm (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .set_vec (alarm_set),
    .clr     (sel.rd && sel.sel_alarm),
    .q       (alarm_q)
  );

  // ----------------------------------------------------------------------
  // Latched C-bit error and tributary frame loss
  // ----------------------------------------------------------------------
  logic [7:0] cbit_set;
  logic [7:0] cbit_q;

  always_comb begin
    cbit_set                         = {1'b0, tributary_oof};
    cbit_set[xl_pkg::CBIT_ERROR_BIT] = c1_valid & ~c1_bit;
  end

  xl_sticky u_cbit (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .set_vec (cbit_set),
    .clr     (sel.rd && sel.sel_cbit),
    .q       (cbit_q)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;

  // Value sampled at the same edge the clear is applied, so nothing is lost
  always_comb begin
    rd_mux = xl_pkg::UNMAPPED_DATA;
    if (sel.sel_rx_xbit) begin
      rd_mux = {1'b0, rx_tributary_xbit};
    end else if (sel.sel_tx_xbit) begin
      rd_mux = {1'b0, tx_xbit_reg};
    end else if (sel.sel_alarm) begin
      rd_mux = alarm_q ^ xl_pkg::XBIT_POS_MASK;
    end else if (sel.sel_cbit) begin
      rd_mux = cbit_q;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rd_data <= xl_pkg::RD_DATA_RESET;
    end else if (sel.rd) begin
      bus_rd_data <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// File: tb/xl_cpu.sv
// Partner: processor model on the register bus
`timescale 1ns/1ps
`default_nettype none
module xl_cpu (
  input  wire logic       ref_clk,
  input  wire logic [7:0] bus_rd_data,
  output logic      [5:0] bus_addr,
  output logic      [7:0] bus_wr_data,
  output logic            bus_rd_en,
  output logic            bus_wr_en
);
  initial {bus_addr, bus_wr_data, bus_rd_en, bus_wr_en} = '0;
  // Strobes stay up for back-to-back access; idle drops them
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    {bus_addr, bus_rd_en, bus_wr_en} = {a, 2'b10};
    @(negedge ref_clk);
    d = bus_rd_data;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a != 6'h18) begin
      {bus_addr, bus_rd_en, bus_wr_en} = {a, 2'b01};
      bus_wr_data = {1'b0, d[6:0]};
      @(negedge ref_clk);
    end else begin
      // Refused write still ends any strobe left up by the last access
      {bus_rd_en, bus_wr_en} = 2'b00;
      @(negedge ref_clk);
    end
  endtask
  task automatic idle();
    {bus_addr, bus_wr_data} = ~{bus_addr, bus_wr_data};
    {bus_rd_en, bus_wr_en} = 2'b00;
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: tb/xl_xbit_alarm_regs_properties.sv
// Checker: port properties of the X-bit and latched alarm bank
`timescale 1ns/1ps
`default_nettype none
module xl_props (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [5:0] bus_addr,
  input wire logic [7:0] bus_wr_data,
  input wire logic       bus_rd_en,
  input wire logic       bus_wr_en,
  input wire logic [7:0] bus_rd_data,
  input wire logic [6:0] rx_tributary_xbit,
  input wire logic [6:0] tx_tributary_xbit,
  input wire logic       line_los,
  input wire logic       line_oof,
  input wire logic       line_ais,
  input wire logic       line_idle,
  input wire logic       rx_clock_fail,
  input wire logic       tx_clock_fail,
  input wire logic [1:0] line_xbit,
  input wire logic       c1_valid,
  input wire logic       c1_bit,
  input wire logic [6:0] tributary_oof
);
  wire logic       rd16 = bus_rd_en && bus_addr == 6'h16;
  wire logic       rd17 = bus_rd_en && bus_addr == 6'h17;
  wire logic       wr15 = bus_wr_en && !bus_rd_en && bus_addr == 6'h15;
  wire logic [5:0] alm  = {line_los, line_oof, line_ais, line_idle,
                           rx_clock_fail, tx_clock_fail};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_RX: assert property (bus_rd_en && bus_addr == 6'h14 |=>
    bus_rd_data == {1'b0, $past(rx_tributary_xbit)}) else $error("rx");
  AST_TX: assert property (wr15 |=>
    {1'b0, tx_tributary_xbit} == ($past(bus_wr_data) & 8'h7F))
    else $error("tx");
  // Snapshot two edges back: the bit is set one edge before the read
  AST_ALM: assert property (rd16 && $past(arst_n) |=>
    (bus_rd_data[7:2] & $past(alm, 2)) == $past(alm, 2)) else $error("alm");
  AST_XBIT: assert property (rd16 && $past(arst_n) |=>
    (bus_rd_data[1:0] & ~$past(line_xbit, 2)) == 2'h0) else $error("xbit");
  // Back-to-back reads: the second shows exactly what was live at the first
  AST_ALM_CLR: assert property (rd16 ##1 rd16 |=>
    bus_rd_data == {$past(alm, 2), $past(line_xbit, 2)}) else $error("aclr");
  AST_CBIT_CLR: assert property (rd17 ##1 rd17 |=>
    bus_rd_data == {$past(c1_valid && !c1_bit, 2), $past(tributary_oof, 2)})
    else $error("cclr");
  AST_RELATCH: assert property (rd16 && line_oof ##1 rd16 |=>
    bus_rd_data[6]) else $error("relatch");
  AST_CERR: assert property (c1_valid && !c1_bit ##1 rd17 |=>
    bus_rd_data[7]) else $error("cerr");
  AST_OOF: assert property (rd17 && $past(arst_n) |=>
    (bus_rd_data[6:0] & $past(tributary_oof, 2)) == $past(tributary_oof, 2))
    else $error("oof");
  cover property (rd16 && line_oof ##1 rd16);
  cover property (c1_valid && !c1_bit ##1 rd17);
  cover property (wr15);
  cover property (rd17 ##1 rd17);
endmodule
bind xl_xbit_alarm_regs xl_props u_props (.*);
`default_nettype wire

// File: tb/xl_xbit_alarm_regs_tb.sv
// Testbench: X-bit and latched alarm register bank
`timescale 1ns/1ps
`default_nettype none
module xl_xbit_alarm_regs_tb;
  logic        ref_clk = 1'b0, arst_n = 1'b0, bus_rd_en, bus_wr_en;
  logic        c1_valid = 1'b0, c1_bit = 1'b1, line_los = 1'b0;
  logic        line_oof = 1'b0, line_ais = 1'b0, line_idle = 1'b0;
  logic        rx_clock_fail = 1'b0, tx_clock_fail = 1'b0;
  logic [1:0]  line_xbit = 2'h3;
  logic [5:0]  bus_addr;
  logic [6:0]  rx_tributary_xbit = 7'h00, tributary_oof = 7'h00;
  logic [6:0]  tx_tributary_xbit;
  logic [7:0]  bus_wr_data, bus_rd_data;
  logic [21:0] rows [3] = '{{7'h55, 8'h2A, 7'h2A}, {7'h2A, 8'hFF, 7'h7F},
                            {7'h7F, 8'h55, 7'h55}};
  int          mismatches = 0, checks_done = 0, cyc = 0;
  xl_xbit_alarm_regs DUT (.*);
  xl_cpu             u_cpu (.*);
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (++cyc == 500) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_cpu.rd(a, v);
    chk(v, exp);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    chk({1'b0, tx_tributary_xbit}, 8'h7F);
    rdc(6'h16, 8'h03);
    rdc(6'h17, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      rx_tributary_xbit = rows[i][21:15];
      u_cpu.wr(6'h15, rows[i][14:7]);
      rdc(6'h15, {1'b0, rows[i][6:0]});
      chk({1'b0, tx_tributary_xbit}, {1'b0, rows[i][6:0]});
      rdc(6'h14, {1'b0, rows[i][21:15]});
    end
    u_cpu.wr(6'h16, 8'h00);
    u_cpu.idle();
    chk({1'b0, tx_tributary_xbit}, 8'h55);
    $display("table test done");
    {line_los, line_oof, line_ais, line_idle} = 4'hF;
    {rx_clock_fail, tx_clock_fail, line_xbit} = 4'hC;
    @(negedge ref_clk);
    {line_los, line_oof, line_ais, line_idle, rx_clock_fail} = 5'h00;
    {tx_clock_fail, line_xbit} = 3'h3;
    rdc(6'h16, 8'hFC);
    rdc(6'h16, 8'h03);
    line_oof = 1'b1;
    rdc(6'h16, 8'h03);
    rdc(6'h16, 8'h43);
    rdc(6'h16, 8'h43);
    line_oof = 1'b0;
    rdc(6'h16, 8'h43);
    rdc(6'h16, 8'h03);
    u_cpu.idle();
    $display("alarm test done");
    {c1_valid, c1_bit, tributary_oof} = 9'h141;
    @(negedge ref_clk);
    {c1_valid, c1_bit, tributary_oof} = 9'h184;
    rdc(6'h17, 8'hC1);
    c1_valid = 1'b0;
    rdc(6'h17, 8'h04);
    tributary_oof = 7'h00;
    rdc(6'h17, 8'h04);
    rdc(6'h17, 8'h00);
    u_cpu.idle();
    $display("cbit test done");
    line_los = 1'b1;
    rdc(6'h15, 8'h55);
    line_los = 1'b0;
    u_cpu.idle();
    arst_n = 1'b0;
    @(negedge ref_clk);
    chk(bus_rd_data, 8'h00);
    chk({1'b0, tx_tributary_xbit}, 8'h7F);
    arst_n = 1'b1;
    rdc(6'h16, 8'h03);
    rdc(6'h18, 8'h00);
    u_cpu.idle();
    $display("midrun reset test done");
    summarize();
  end
endmodule
`default_nettype wire
